/* File: adc_serial_regs.vh */
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH
// ==========================================================
// Control byte layout
`define CTRL_WIDTH        8
`define CTRL_CHAN_MSB     5
`define CTRL_CHAN_LSB     3
`define CTRL_RESET        8'h00
`define CHAN_RESET        3'h0
// ==========================================================
// Conversion timing in serial clock cycles
`define CONV_CYCLES       5'h10
`define TRACK_CYCLES      5'h03
`define HOLD_FALL         5'h04
`define DATA_FIRST_FALL   5'h05
`define DATA_LAST_FALL    5'h0E
`define CTRL_RISES        5'h08
`define RESULT_WIDTH      10
`endif

/* File: adc_result_fifo.v */
`default_nettype none
// ==========================================================
// Result FIFO
module adc_result_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             i_clk,    // Clock
    input  wire             i_rstn,   // Sync reset, active low
    input  wire [WIDTH-1:0] i_data,   // Write data
    input  wire             i_valid,  // Write request
    output wire             o_ready,  // Not full
    output wire [WIDTH-1:0] o_data,   // Head word
    output wire             o_valid,  // Not empty
    input  wire             i_ready   // Drain accepts
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp_q;
    reg [AW:0]      rp_q;
    wire            full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire            empty = (wp_q == rp_q);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rp_q[AW-1:0]];
    always @(posedge i_clk) begin
        if (i_valid && !full)
            mem[wp_q[AW-1:0]] <= i_data;
    end
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end else begin
            if (i_valid && !full)
                wp_q <= wp_q + 1'b1;
            if (i_ready && !empty)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: adc_serial_port.v */
`include "adc_serial_regs.vh"
`default_nettype none
module adc_serial_port #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire       I_CLK,          // 250 MHz system clock
    input  wire       I_RSTN,         // Sync reset, active low
    input  wire       I_CS_N,         // Frame select pin, active low
    input  wire       I_SCLK,         // Serial clock pin
    input  wire       I_DIN,          // Control serial input pin
    output reg        O_DOUT,         // Serial result output
    output wire       O_DOUT_OE,      // Output enable of result pin
    output wire       O_TRACK,        // Sampler in track mode
    output wire       O_POWERED,      // Converter powered
    output wire       O_SAMPLE_REQ,   // Pulse: take sample now
    output wire [2:0] O_SAMPLE_CHAN,  // Channel to sample
    input  wire [9:0] I_SAMPLE_CODE,  // Model code, straight binary
    output wire [9:0] O_RES_DATA,     // Result FIFO head
    output wire       O_RES_VALID,    // Result FIFO not empty
    input  wire       I_RES_READY,    // Result drain accepts
    output wire [2:0] O_CHAN          // Channel for next conversion
);
    // ==========================================================
    // Pin synchronisers
    localparam       NSYNC    = 3;
    // Reset levels: select idles high so no false frame start follows reset
    localparam [2:0] PIN_IDLE = 3'h1;
    wire [NSYNC-1:0] pin_raw  = {I_DIN, I_SCLK, I_CS_N};
    wire [NSYNC-1:0] pin_sync;
    genvar           gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            reg [1:0] sync_q;
            always @(posedge I_CLK) begin
                if (!I_RSTN)
                    sync_q <= {2{PIN_IDLE[gi]}};
                else
                    sync_q <= {sync_q[0], pin_raw[gi]};
            end
            assign pin_sync[gi] = sync_q[1];
        end
    endgenerate

    wire       cs_n = pin_sync[0];
    wire       sclk = pin_sync[1];
    wire       din  = pin_sync[2];
    reg        cs_n_q;
    reg        sclk_q;
    // Delayed copies for edge detection
    always @(posedge I_CLK) begin
        if (!I_RSTN) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            cs_n_q <= cs_n;
            sclk_q <= sclk;
        end
    end
    wire cs_fall  = cs_n_q && !cs_n;
    wire in_frame = !cs_n && !cs_n_q;
    // Clock edges gated by the frame
    wire rise     = in_frame && !sclk_q && sclk;
    wire sfall    = in_frame && sclk_q && !sclk;
    // Select falling with clock low (or together) counts as fall one
    wire start_fall = cs_fall && !sclk;
    wire fall       = sfall || start_fall;

    // ==========================================================
    // Conversion sequencer
    localparam ST_IDLE  = 2'h0;
    localparam ST_TRACK = 2'h1;
    localparam ST_HOLD  = 2'h2;
    localparam ST_DOWN  = 2'h3;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [4:0]  fall_cnt_q;
    reg  [4:0]  rise_cnt_q;
    reg  [7:0]  ctrl_q;
    reg  [2:0]  chan_q;
    reg  [9:0]  shift_q;
    reg         samp_q;
    reg         push_q;
    wire        fifo_ready;
    wire [4:0]  fall_num = fall_cnt_q + 5'h01;

    // ==========================================================
    // Edge-count decodes
    function is_hold_fall;
        input [4:0] num;
        begin
            is_hold_fall = (num == `HOLD_FALL);
        end
    endfunction

    function is_data_fall;
        input [4:0] num;
        begin
            is_data_fall = (num >= `DATA_FIRST_FALL) && (num <= `DATA_LAST_FALL);
        end
    endfunction

    function is_last_rise;
        input [4:0] cnt;
        begin
            is_last_rise = (cnt == `CONV_CYCLES - 5'h01);
        end
    endfunction

    wire hold_fall  = fall && is_hold_fall(fall_num);
    wire data_fall  = fall && is_data_fall(fall_num);
    wire last_rise  = rise && is_last_rise(rise_cnt_q);
    wire frame_edge = cs_n || cs_fall;

    // ==========================================================
    // Sequencer state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (fall)
                    state_d = ST_TRACK;
            end
            ST_TRACK: begin
                if (hold_fall)
                    state_d = ST_HOLD;
            end
            ST_HOLD: begin
                // Asleep from the last rise until the next first fall
                if (last_rise)
                    state_d = ST_DOWN;
            end
            ST_DOWN: begin
                if (fall)
                    state_d = ST_TRACK;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (cs_n)
            state_d = ST_IDLE;
    end

    always @(posedge I_CLK) begin
        if (!I_RSTN)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // Edge counters, restarted at every frame boundary
    always @(posedge I_CLK) begin
        if (!I_RSTN)
            fall_cnt_q <= 5'h00;
        else if (fall)
            fall_cnt_q <= (fall_num == `CONV_CYCLES) ? 5'h00 : fall_num;
        else if (frame_edge)
            fall_cnt_q <= 5'h00;
    end

    always @(posedge I_CLK) begin
        if (!I_RSTN)
            rise_cnt_q <= 5'h00;
        else if (frame_edge)
            rise_cnt_q <= 5'h00;
        else if (rise)
            rise_cnt_q <= is_last_rise(rise_cnt_q) ? 5'h00 : rise_cnt_q + 5'h01;
    end

    // ==========================================================
    // Control byte and channel address
    always @(posedge I_CLK) begin
        if (!I_RSTN)
            ctrl_q <= `CTRL_RESET;
        else if (rise && rise_cnt_q < `CTRL_RISES)
            ctrl_q <= {ctrl_q[6:0], din};
    end

    // Read one bit below the field: the eighth bit is shifting in on this edge
    always @(posedge I_CLK) begin
        if (!I_RSTN)
            chan_q <= `CHAN_RESET;
        else if (rise && rise_cnt_q == `CTRL_RISES - 5'h01)
            chan_q <= ctrl_q[`CTRL_CHAN_MSB-1:`CTRL_CHAN_LSB-1];
    end

    // ==========================================================
    // Result shifter and pin
    always @(posedge I_CLK) begin
        if (!I_RSTN)
            shift_q <= 10'h000;
        else if (hold_fall)
            shift_q <= I_SAMPLE_CODE;
        else if (data_fall)
            shift_q <= {shift_q[`RESULT_WIDTH-2:0], 1'b0};
    end

    always @(posedge I_CLK) begin
        if (!I_RSTN)
            O_DOUT <= 1'b0;
        else if (data_fall)
            O_DOUT <= shift_q[`RESULT_WIDTH-1];
        else if (fall || frame_edge)
            O_DOUT <= 1'b0;
    end

    // ==========================================================
    // Sample and push strobes
    always @(posedge I_CLK) begin
        if (!I_RSTN) begin
            samp_q <= 1'b0;
            push_q <= 1'b0;
        end else begin
            samp_q <= hold_fall;
            push_q <= last_rise && fifo_ready;
        end
    end

    reg [9:0] result_q;
    always @(posedge I_CLK) begin
        if (!I_RSTN)
            result_q <= 10'h000;
        else if (samp_q)
            result_q <= shift_q;
    end

    assign O_DOUT_OE     = !cs_n;
    // ==========================================================
    // Status decode
    reg track_c;
    reg powered_c;
    always @* begin
        track_c   = 1'b0;
        powered_c = 1'b0;
        case (state_q)
            ST_TRACK: begin
                track_c   = 1'b1;
                powered_c = 1'b1;
            end
            ST_HOLD: begin
                powered_c = 1'b1;
            end
            default: begin
                track_c   = 1'b0;
                powered_c = 1'b0;
            end
        endcase
    end

    assign O_TRACK       = track_c;
    assign O_POWERED     = powered_c;
    assign O_SAMPLE_REQ  = hold_fall && (state_q == ST_TRACK);
    assign O_SAMPLE_CHAN = chan_q;
    assign O_CHAN        = chan_q;

    // ==========================================================
    // Result buffering; a full FIFO drops the newest result
    adc_result_fifo #(
        .WIDTH (`RESULT_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .i_clk   (I_CLK),
        .i_rstn  (I_RSTN),
        .i_data  (result_q),
        .i_valid (push_q),
        .o_ready (fifo_ready),
        .o_data  (O_RES_DATA),
        .o_valid (O_RES_VALID),
        .i_ready (I_RES_READY)
    );
endmodule
`default_nettype wire

/* File: adc_serial_port_asserts.sv */
`default_nettype none
// ==========================================================
// Pin-level checks
module adc_serial_port_asserts (
    input wire logic       I_CLK,        // Clock
    input wire logic       I_RSTN,       // Sync reset
    input wire logic       I_CS_N,       // Frame select
    input wire logic       O_DOUT,       // Result bit
    input wire logic       O_DOUT_OE,    // Result enable
    input wire logic       O_TRACK,      // Track mode
    input wire logic       O_POWERED,    // Powered
    input wire logic       O_SAMPLE_REQ, // Sample pulse
    input wire logic [2:0] O_CHAN        // Next channel
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    a_oe_idle: assert property (I_CS_N [*4] |-> !O_DOUT_OE) else $error("output driven while idle");
    a_oe_frame: assert property ((!I_CS_N) [*4] |-> O_DOUT_OE) else $error("output off in frame");
    a_idle_off: assert property (I_CS_N [*4] |-> !O_POWERED) else $error("powered while idle");
    a_idle_noreq: assert property (I_CS_N [*4] |-> !O_SAMPLE_REQ) else $error("sample while idle");
    a_idle_chan: assert property (I_CS_N [*4] |-> $stable(O_CHAN)) else $error("channel moved idle");
    a_req_pulse: assert property (O_SAMPLE_REQ |=> !O_SAMPLE_REQ) else $error("sample pulse too long");
    a_req_hold: assert property ($rose(O_SAMPLE_REQ) |-> ##[0:2] !O_TRACK) else $error("no hold");
    a_req_zero: assert property (O_SAMPLE_REQ |-> !O_DOUT) else $error("lead bit not zero");
    a_track_pwr: assert property (O_TRACK |-> O_POWERED) else $error("tracking unpowered");
endmodule
bind adc_serial_port adc_serial_port_asserts adc_serial_port_asserts_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_CS_N(I_CS_N), .O_DOUT(O_DOUT), .O_DOUT_OE(O_DOUT_OE), .O_TRACK(O_TRACK), .O_POWERED(O_POWERED),
    .O_SAMPLE_REQ(O_SAMPLE_REQ), .O_CHAN(O_CHAN));
`default_nettype wire

/* File: adc_host_model.sv */
`default_nettype none
// ==========================================================
// Host serial controller
module adc_host_model (
    output logic o_cs_n, // Frame select
    output logic o_sclk, // Serial clock, still between frames
    output logic o_din,  // Control bits
    input wire logic i_dout  // Result line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] rx[$];
    initial begin
        o_cs_n = 1;
        o_sclk = 1;
        o_din = 0;
    end
    // Mode 0 clock high, 1 clock low, 2 both fall together
    task automatic frame(input logic [7:0] c, input int n, m);
        logic [15:0] w;
        int i;
        o_sclk = (m != 1);
        #40;
        if (m == 2) o_sclk = 0;
        o_cs_n = 0;
        for (int k = 0; k < n; k++) begin
            i = 15 - k % 16;
            #62.5 o_sclk = 0;
            o_din = (k % 16 < 8) ? c[7 - k % 16] : !o_din;
            #62.5 o_sclk = 1;
            w[i] = i_dout;
            if (i == 0) rx.push_back(w);
        end
        #40 o_cs_n = 1;
        o_din = !o_din;
    endtask
endmodule
`default_nettype wire

/* File: adc_serial_port_test.sv */
`default_nettype none
// ==========================================================
// Bench
module adc_serial_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        I_CLK = 0;
    logic        I_RSTN = 0;
    logic        I_RES_READY = 0;
    logic [9:0]  I_SAMPLE_CODE = 0;
    wire         cs_n, sclk, din, dout, oe, rvld;
    wire  [2:0]  schan, chan;
    wire  [9:0]  rdat;
    int          errors = 0, n_checks = 0, cyc = 0;
    logic [15:0] exp[$];
    always #2 I_CLK = ~I_CLK;
    // Code encodes the channel so a wrong mux shows in the word
    always @(posedge I_CLK) I_SAMPLE_CODE <= {schan, 7'h5A};
    always @(posedge I_CLK) if (++cyc == 20000) begin
        errors++;
        test_done;
    end
    adc_serial_port adc_serial_port_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CS_N(cs_n), .I_SCLK(sclk),
        .I_DIN(din), .O_DOUT(dout), .O_DOUT_OE(oe), .O_TRACK(), .O_POWERED(), .O_SAMPLE_REQ(),
        .O_SAMPLE_CHAN(schan), .I_SAMPLE_CODE(I_SAMPLE_CODE), .O_RES_DATA(rdat), .O_RES_VALID(rvld),
        .I_RES_READY(I_RES_READY), .O_CHAN(chan));
    adc_host_model adc_host_model_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(oe ? dout : 1'bz));
    task chk(input logic [15:0] g, e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // First conversion from channel a, the rest from b
    task automatic run(input logic [7:0] c, input int n, m, input logic [2:0] a, b);
        int base = exp.size();
        for (int k = 0; k < n / 16; k++) exp.push_back({4'h0, (k ? b : a), 7'h5A, 2'b00});
        adc_host_model_inst.frame(c, n, m);
        repeat (8) @(posedge I_CLK);
        chk(adc_host_model_inst.rx.size(), n / 16);
        while (adc_host_model_inst.rx.size()) chk(adc_host_model_inst.rx.pop_front(), exp[base++]);
    endtask
    task t_first;
        run(8'hEF, 16, 0, 0, 0);
        chk(chan, 5);
    endtask
    task t_multi;
        run(8'h10, 48, 1, 5, 2);
        chk(chan, 2);
    endtask
    task t_short;
        run(8'h38, 5, 2, 0, 0);
        chk(chan, 2);
        run(8'h10, 16, 2, 2, 2);
    endtask
    task t_fill;
        run(8'h00, 192, 0, 2, 0);
        chk(rvld, 1);
    endtask
    task t_drain;
        for (int k = 0; k < 16; k++) begin
            @(negedge I_CLK);
            chk({rvld, rdat}, {1'b1, exp[k][11:2]});
            @(posedge I_CLK) I_RES_READY <= 1;
            @(posedge I_CLK) I_RES_READY <= 0;
        end
        repeat (2) @(posedge I_CLK);
        chk(rvld, 0);
    endtask
    task test_done;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge I_CLK);
        I_RSTN <= 1;
        repeat (3) @(posedge I_CLK);
        t_first;
        t_multi;
        t_short;
        t_fill;
        t_drain;
        test_done;
    end
endmodule
`default_nettype wire
